// ### alarm_irq_pkg.sv
package alarm_irq_pkg;

	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int IDX_W = ADDR_W - 2;
	// Status groups: alarm, error/timer, slip/channel 2, transmit events
	localparam int NGRP = 4;

	// Register indices; the byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_ALARM = 10'h06a;
	localparam logic [IDX_W-1:0] IDX_ERRTMR = 10'h06b;
	localparam logic [IDX_W-1:0] IDX_SLIP = 10'h06c;
	localparam logic [IDX_W-1:0] IDX_TXEV = 10'h047;
	localparam logic [IDX_W-1:0] IDX_CFG = 10'h040;
	localparam logic [IDX_W-1:0] IDX_LOOP = 10'h041;
	localparam logic [IDX_W-1:0] IDX_ERRSEC_MASK = 10'h042;
	localparam logic [IDX_W-1:0] IDX_MASK0 = 10'h043;
	localparam logic [IDX_W-1:0] IDX_SUM = 10'h048;
	localparam logic [IDX_W-1:0] IDX_LINE = 10'h049;

	// Alarm event status fields
	localparam int B_FRM_REC = 7;
	localparam int B_FRM_LOST = 6;
	localparam int B_MF_REC = 5;
	localparam int B_MF_LOST = 4;
	localparam int B_BLUE = 3;
	localparam int B_RED = 2;
	localparam int B_REM_REC = 1;
	localparam int B_REM_ALM = 0;
	// Error/timer event status fields
	localparam int B_ERR_SEC = 7;
	localparam int B_TICK = 6;
	localparam int B_LOOP_CHG = 2;
	localparam int B_RX_SLIP_N = 1;
	localparam int B_RX_SLIP_P = 0;
	// Slip/channel 2 event status fields
	localparam int B_TX_SLIP_P = 7;
	localparam int B_TX_SLIP_N = 6;
	localparam int B_MSG_END2 = 5;
	localparam int B_FRM_START2 = 4;
	localparam int B_OVFL2 = 3;
	localparam int B_ALL_SENT2 = 2;
	localparam int B_UNDERRUN2 = 1;
	localparam int B_POOL_FULL2 = 0;
	// Transmit event status fields
	localparam int B_MF_BEGIN = 3;
	localparam int B_SU_ERR = 2;
	localparam int B_LINE_CHG = 1;
	localparam int B_POOL_READY = 0;
	// Configuration fields
	localparam int B_SHOW_MASKED = 0;
	localparam int B_CHG_SEL = 1;
	localparam int B_PRBS = 0;
	// Line state readback fields
	localparam int B_LN_ACT = 1;
	localparam int B_LN_DEACT = 0;

	// Reset values
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'hff;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] ESM_RST = 8'h00;

	// Receive line rate, edges per second
	localparam int unsigned RX_LINE_HZ = 1544000;

endpackage

// ### alarm_irq_status.sv
`timescale 1ns/10ps
`default_nettype none

module alarm_irq_status #(
	parameter int unsigned SECOND_DIV = alarm_irq_pkg::RX_LINE_HZ
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [alarm_irq_pkg::ADDR_W-1:0] paddr,
	input wire logic [alarm_irq_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [alarm_irq_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_line_clk,
	input wire logic alarm_sim,
	input wire logic multiframe_format,
	input wire logic frame_align_lost,
	input wire logic multiframe_align_lost,
	input wire logic blue_alarm,
	input wire logic red_alarm,
	input wire logic remote_alarm_flag,
	input wire logic tx_line_open,
	input wire logic tx_line_short,
	input wire logic loop_activate_detected,
	input wire logic loop_deactivate_detected,
	input wire logic prbs_sync,
	input wire logic ss7_mode,
	input wire logic signal_unit_error_over,
	input wire logic su_abort_cause,
	input wire logic su_valid_frame,
	input wire logic tx_multiframe_begin,
	input wire logic tx_pool_ready,
	input wire logic framing_error,
	input wire logic crc_error,
	input wire logic code_violation,
	input wire logic rx_slip_negative,
	input wire logic rx_slip_positive,
	input wire logic tx_slip_positive,
	input wire logic tx_slip_negative,
	input wire logic rx_message_end_ch2,
	input wire logic rx_frame_start_ch2,
	input wire logic rx_overflow_ch2,
	input wire logic all_sent_ch2,
	input wire logic tx_underrun_ch2,
	input wire logic rx_pool_full_ch2,
	output logic irq
);
	import alarm_irq_pkg::*;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic [NGRP-1:0][7:0] st_r;
	logic [NGRP-1:0][7:0] mask_r;
	logic [NGRP-1:0][7:0] set_v;
	wire [NGRP-1:0][7:0] lat;
	wire [NGRP-1:0][7:0] st_nxt;
	wire [NGRP-1:0][7:0] mask_nxt;
	wire [NGRP-1:0] hit_st;
	wire [NGRP-1:0] hit_mask;
	wire [NGRP-1:0] pend;
	logic [7:0] cfg_r;
	logic [7:0] loop_r;
	logic [7:0] errsec_mask_r;
	logic [10:0] prev_r;
	logic [6:0] errsec_acc_r;
	logic su_rep_r;
	logic irq_r;
	logic [DATA_W-1:0] prdata_r;
	logic err_r;
	logic [DATA_W-1:0] rd_val;
	logic rd_hit;
	logic [7:0] st_sel;
	logic [7:0] mask_sel;
	logic second_tick;

	// Bus phases; zero wait states, the answer is ready in the first access cycle
	wire logic [IDX_W-1:0] idx = paddr[ADDR_W-1:2];
	wire logic setup_ph = psel & ~penable;
	wire logic access_ph = psel & penable;
	wire logic wr_en = access_ph & pwrite & pstrb[0];
	wire logic rd_acc = access_ph & ~pwrite;
	wire logic show_masked = cfg_r[B_SHOW_MASKED];
	wire logic chg_sel = cfg_r[B_CHG_SEL];
	wire logic prbs_sel = loop_r[B_PRBS];

	// Second timer on the receive line clock
	rx_second_timer #(.DIV(SECOND_DIV)) u_second (
		.pclk(pclk),
		.presetn(presetn),
		.rx_line_clk(rx_line_clk),
		.tick(second_tick)
	);

	// Current flags and their values one cycle ago, for edge detection
	wire logic [10:0] flags = {alarm_sim, frame_align_lost, multiframe_align_lost, blue_alarm,
		red_alarm, remote_alarm_flag, tx_line_open, tx_line_short,
		loop_activate_detected, loop_deactivate_detected, prbs_sync};
	wire logic p_sim = prev_r[10];
	wire logic p_frm = prev_r[9];
	wire logic p_mf = prev_r[8];
	wire logic p_blue = prev_r[7];
	wire logic p_red = prev_r[6];
	wire logic p_rem = prev_r[5];
	wire logic p_open = prev_r[4];
	wire logic p_short = prev_r[3];
	wire logic p_act = prev_r[2];
	wire logic p_deact = prev_r[1];
	wire logic p_prbs = prev_r[0];
	wire logic sim_rise = alarm_sim & ~p_sim;
	wire logic sim_fall = ~alarm_sim & p_sim;

	// Alarm events; simulation forces each alarm once at its start, the multiframe ones only in multiframe format
	wire logic frm_rec_s = (~frame_align_lost & p_frm) | (sim_fall & ~frame_align_lost);
	wire logic frm_lost_s = (frame_align_lost & ~p_frm) | sim_rise;
	wire logic mf_rec_s = multiframe_format & ((~multiframe_align_lost & p_mf) | sim_rise);
	wire logic mf_lost_s = multiframe_format & ((multiframe_align_lost & ~p_mf) | sim_rise);
	wire logic blue_s = (chg_sel ? (blue_alarm ^ p_blue) : (blue_alarm & ~p_blue)) | sim_rise;
	wire logic red_s = (chg_sel ? (red_alarm ^ p_red) : (red_alarm & ~p_red)) | sim_rise;
	wire logic rem_rec_s = (~remote_alarm_flag & p_rem) | (sim_fall & ~remote_alarm_flag);
	wire logic rem_s = (remote_alarm_flag & ~p_rem) | sim_rise;

	// Loop code or PRBS change, selected by the loop configuration
	wire logic loop_chg = (loop_activate_detected ^ p_act) | (loop_deactivate_detected ^ p_deact);
	wire logic loop_s = prbs_sel ? (prbs_sync ^ p_prbs) : loop_chg;
	wire logic line_s = (tx_line_open & ~p_open) | (tx_line_short ^ p_short);
	wire logic slip_n_s = rx_slip_negative | sim_rise;
	wire logic slip_p_s = rx_slip_positive | sim_rise;

	// Signalling unit errors repeat once a second after an abort until a good frame
	wire logic su_err_s = ss7_mode & (signal_unit_error_over | (su_rep_r & second_tick));

	// Errored second sources in mask order: frame loss, framing, CRC, blue, red, code, slip
	wire logic any_slip = slip_n_s | slip_p_s | tx_slip_positive | tx_slip_negative;
	wire logic [6:0] errsec_src = {frm_lost_s, framing_error, crc_error, blue_s, red_s,
		code_violation, any_slip} & errsec_mask_r[6:0];
	wire logic errsec_s = second_tick & (|errsec_acc_r | |errsec_src);

	// Event vectors per status register
	always_comb begin
		set_v = '0;
		set_v[0][B_FRM_REC] = frm_rec_s;
		set_v[0][B_FRM_LOST] = frm_lost_s;
		set_v[0][B_MF_REC] = mf_rec_s;
		set_v[0][B_MF_LOST] = mf_lost_s;
		set_v[0][B_BLUE] = blue_s;
		set_v[0][B_RED] = red_s;
		set_v[0][B_REM_REC] = rem_rec_s;
		set_v[0][B_REM_ALM] = rem_s;
		set_v[1][B_ERR_SEC] = errsec_s;
		set_v[1][B_TICK] = second_tick;
		set_v[1][B_LOOP_CHG] = loop_s;
		set_v[1][B_RX_SLIP_N] = slip_n_s;
		set_v[1][B_RX_SLIP_P] = slip_p_s;
		set_v[2][B_TX_SLIP_P] = tx_slip_positive;
		set_v[2][B_TX_SLIP_N] = tx_slip_negative;
		set_v[2][B_MSG_END2] = rx_message_end_ch2;
		set_v[2][B_FRM_START2] = rx_frame_start_ch2;
		set_v[2][B_OVFL2] = rx_overflow_ch2;
		set_v[2][B_ALL_SENT2] = all_sent_ch2;
		set_v[2][B_UNDERRUN2] = tx_underrun_ch2;
		set_v[2][B_POOL_FULL2] = rx_pool_full_ch2;
		set_v[3][B_MF_BEGIN] = tx_multiframe_begin;
		set_v[3][B_SU_ERR] = su_err_s;
		set_v[3][B_LINE_CHG] = line_s;
		set_v[3][B_POOL_READY] = tx_pool_ready;
	end

	// Per group: latch gate, clear on read, mask write, pending summary.
	// Only bits returned by the read are cleared, so an event landing between
	// setup and access is kept; a set in the clearing cycle also wins.
	genvar g;
	generate
		for (g = 0; g < NGRP; g++) begin : grp
			assign hit_st[g] = (idx == (g == 0 ? IDX_ALARM : g == 1 ? IDX_ERRTMR :
				g == 2 ? IDX_SLIP : IDX_TXEV));
			assign hit_mask[g] = (idx == IDX_MASK0 + IDX_W'(g));
			assign lat[g] = set_v[g] & (~mask_r[g] | {8{show_masked}});
			assign st_nxt[g] = (st_r[g] & ~({8{rd_acc & hit_st[g]}} & prdata_r[7:0]))
				| lat[g];
			assign mask_nxt[g] = (wr_en & hit_mask[g]) ? pwdata[7:0] : mask_r[g];
			assign pend[g] = |(st_r[g] & ~mask_r[g]);
		end
	endgenerate

	// Status, masks and interrupt line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= {NGRP{STAT_RST}};
			mask_r <= {NGRP{MASK_RST}};
			irq_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			mask_r <= mask_nxt;
			irq_r <= |pend;
		end
	end

	// Configuration registers written by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r <= CFG_RST;
			loop_r <= CFG_RST;
			errsec_mask_r <= ESM_RST;
		end else if (wr_en) begin
			if (idx == IDX_CFG) begin
				cfg_r <= pwdata[7:0];
			end else if (idx == IDX_LOOP) begin
				loop_r <= pwdata[7:0];
			end else if (idx == IDX_ERRSEC_MASK) begin
				errsec_mask_r <= pwdata[7:0];
			end
		end
	end

	// Edge history, errored second window and signalling unit repeat
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r <= '0;
			errsec_acc_r <= '0;
			su_rep_r <= 1'b0;
		end else begin
			prev_r <= flags;
			errsec_acc_r <= second_tick ? '0 : (errsec_acc_r | errsec_src);
			if (!ss7_mode || su_valid_frame) begin
				su_rep_r <= 1'b0;
			end else if (signal_unit_error_over && su_abort_cause) begin
				su_rep_r <= 1'b1;
			end
		end
	end

	// Selected status and mask for the read mux
	always_comb begin
		st_sel = '0;
		mask_sel = '0;
		for (int i = 0; i < NGRP; i++) begin
			if (hit_st[i]) begin
				st_sel = st_r[i];
			end
			if (hit_mask[i]) begin
				mask_sel = mask_r[i];
			end
		end
	end

	// Read decode; unmapped addresses read zero and raise pslverr
	always_comb begin
		rd_val = '0;
		rd_hit = 1'b1;
		if (idx == IDX_CFG) begin
			rd_val[7:0] = cfg_r;
		end else if (idx == IDX_LOOP) begin
			rd_val[7:0] = loop_r;
		end else if (idx == IDX_ERRSEC_MASK) begin
			rd_val[7:0] = errsec_mask_r;
		end else if (idx == IDX_SUM) begin
			rd_val[NGRP-1:0] = pend;
		end else if (idx == IDX_LINE) begin
			rd_val[B_LN_ACT] = prbs_sel ? prbs_sync : loop_activate_detected;
			rd_val[B_LN_DEACT] = loop_deactivate_detected;
		end else if (|hit_st) begin
			rd_val[7:0] = st_sel;
		end else if (|hit_mask) begin
			rd_val[7:0] = mask_sel;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// Read data is caught in the setup cycle so the clear knows what was seen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= '0;
			err_r <= 1'b0;
		end else if (setup_ph) begin
			prdata_r <= pwrite ? '0 : rd_val;
			err_r <= ~rd_hit;
		end
	end

	assign prdata = prdata_r;
	assign pready = access_ph;
	assign pslverr = access_ph & err_r;
	assign irq = irq_r;

	// Checks
	property p_read_clear;
		rd_acc && hit_st[0] && lat[0] == 8'h00 && $past(lat[0]) == 8'h00 && $past(setup_ph)
			|=> st_r[0] == 8'h00;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("status not cleared by read");

	property p_show_latch;
		show_masked && mask_r[0][B_FRM_LOST] && frm_lost_s
			|=> st_r[0][B_FRM_LOST] ##1 !pend[0] || !mask_r[0][B_FRM_LOST];
	endproperty
	a_show_latch: assert property (p_show_latch) else $error("masked visible status misbehaves");

	property p_hidden;
		!show_masked && mask_r[3] == 8'hff && st_r[3] == 8'h00 && !(wr_en && hit_mask[3])
			|=> st_r[3] == 8'h00;
	endproperty
	a_hidden: assert property (p_hidden) else $error("masked status latched while hidden");

	property p_mf_begin;
		tx_multiframe_begin && !mask_r[3][B_MF_BEGIN] |=> st_r[3][B_MF_BEGIN];
	endproperty
	a_mf_begin: assert property (p_mf_begin) else $error("multiframe begin not latched");

	property p_su_err_mode;
		!ss7_mode && st_r[3][B_SU_ERR] == 1'b0 |=> st_r[3][B_SU_ERR] == 1'b0;
	endproperty
	a_su_err_mode: assert property (p_su_err_mode) else $error("unit error outside SS7 mode");

	property p_line_chg;
		$changed(tx_line_short) && lat[3] == set_v[3] |=> st_r[3][B_LINE_CHG];
	endproperty
	a_line_chg: assert property (p_line_chg) else $error("short-line change missed");

	property p_frm_rec;
		$fell(frame_align_lost) && !mask_r[0][B_FRM_REC] |=> st_r[0][B_FRM_REC];
	endproperty
	a_frm_rec: assert property (p_frm_rec) else $error("alignment recovery missed");

	property p_sim_start;
		$rose(alarm_sim) && show_masked
			|=> st_r[0][B_FRM_LOST] && st_r[0][B_BLUE] && st_r[1][B_RX_SLIP_N];
	endproperty
	a_sim_start: assert property (p_sim_start) else $error("simulation did not set alarms");

	property p_blue_chg;
		chg_sel && show_masked && $fell(blue_alarm) |=> st_r[0][B_BLUE];
	endproperty
	a_blue_chg: assert property (p_blue_chg) else $error("blue alarm change missed");

	property p_tick;
		second_tick && show_masked |=> st_r[1][B_TICK] ##1 !second_tick;
	endproperty
	a_tick: assert property (p_tick) else $error("second tick not latched");

	property p_irq;
		lat[2] != 8'h00 && (lat[2] & ~mask_r[2]) != 8'h00 |=> ##1 irq;
	endproperty
	a_irq: assert property (p_irq) else $error("unmasked event gave no interrupt");

	c_read: cover property (rd_acc && hit_st[0] && st_r[0] != 8'h00);
	c_sim_end: cover property ($fell(alarm_sim) ##1 st_r[0][B_FRM_REC]);
	c_errsec: cover property (errsec_s);
	c_irq: cover property ($rose(irq));

endmodule
`default_nettype wire

// ### rx_second_timer.sv
`timescale 1ns/10ps
`default_nettype none

module rx_second_timer #(
	parameter int unsigned DIV = alarm_irq_pkg::RX_LINE_HZ
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic rx_line_clk,
	output logic tick
);
	import alarm_irq_pkg::*;

	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [2:0] sync_r;
	logic lvl_r;
	logic [CW-1:0] cnt_r;
	logic tick_r;

	// The line clock is a foreign pin; only a level seen by two stages counts
	wire logic settled = (sync_r[1] == sync_r[2]);
	wire logic rise = settled & sync_r[2] & ~lvl_r;
	wire logic wrap = (cnt_r == LAST);

	// Synchroniser, filtered level and edge counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_r <= 3'h0;
			lvl_r <= 1'b0;
			cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			sync_r <= {sync_r[1:0], rx_line_clk};
			if (settled) begin
				lvl_r <= sync_r[2];
			end
			if (rise) begin
				cnt_r <= wrap ? '0 : cnt_r + 1'b1;
			end
			tick_r <= rise & wrap;
		end
	end

	assign tick = tick_r;

endmodule
`default_nettype wire

// ### test_framer_alarm_interrupt_status.sv
`timescale 1ns/10ps
`default_nettype none

module test_framer_alarm_interrupt_status;
	import alarm_irq_pkg::*;

	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd_data;
	logic [3:0] pstrb;
	logic rx_line_clk, rx_run, ss7, abort_cause, rd_err;
	logic [1:0] rx_div;
	logic [16:0] pv;
	logic [11:0] lv;
	logic [IDX_W-1:0] ix;
	logic [7:0] ex;
	int err_count, samples_checked;

	localparam int NR = 38;
	// Row: kind (00 pulse, 01 flip a flag, 02 none), input number, register index, expected
	localparam logic [31:0] ROWS [NR] = '{
		32'h0000_4708, 32'h0001_4701, 32'h0002_6b02, 32'h0003_6b01, 32'h0004_6c80,
		32'h0005_6c40, 32'h0006_6c20, 32'h0007_6c10, 32'h0008_6c08, 32'h0009_6c04,
		32'h000a_6c02, 32'h000b_6c01, 32'h000f_4700, 32'h0100_6a40, 32'h0100_6a80,
		32'h0101_6a10, 32'h0101_6a20, 32'h0102_6a08, 32'h0102_6a00, 32'h0103_6a04,
		32'h0103_6a00, 32'h0104_6a01, 32'h0104_6a02, 32'h0105_4702, 32'h0105_4700,
		32'h0106_4702, 32'h0106_4702, 32'h0107_6b04, 32'h0107_6b04, 32'h0108_6b04,
		32'h0108_6b04, 32'h010a_6a7d, 32'h0200_6b03, 32'h010a_6a82, 32'h010b_6a00,
		32'h0101_6a00, 32'h0101_6a00, 32'h010b_6a00};
	localparam logic [IDX_W-1:0] ZERO_IDX [8] = '{IDX_CFG, IDX_LOOP, IDX_ERRSEC_MASK, IDX_ALARM,
		IDX_ERRTMR, IDX_SLIP, IDX_TXEV, IDX_SUM};

	always #4 pclk = ~pclk;

	// Line clock of eight pclk per period; parked outside the timer test so that
	// no second tick lands in the middle of the table
	always @(posedge pclk) begin
		if (rx_run) begin
			rx_div <= rx_div + 2'h1;
			if (rx_div == 2'h3) begin
				rx_line_clk <= ~rx_line_clk;
			end
		end
	end

	alarm_irq_status #(.SECOND_DIV(20)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_line_clk(rx_line_clk), .alarm_sim(lv[10]),
		.multiframe_format(lv[11]), .frame_align_lost(lv[0]), .multiframe_align_lost(lv[1]),
		.blue_alarm(lv[2]), .red_alarm(lv[3]), .remote_alarm_flag(lv[4]),
		.tx_line_open(lv[5]), .tx_line_short(lv[6]), .loop_activate_detected(lv[7]),
		.loop_deactivate_detected(lv[8]), .prbs_sync(lv[9]), .ss7_mode(ss7),
		.signal_unit_error_over(pv[15]), .su_abort_cause(abort_cause),
		.su_valid_frame(pv[16]), .tx_multiframe_begin(pv[0]), .tx_pool_ready(pv[1]),
		.framing_error(pv[12]), .crc_error(pv[13]), .code_violation(pv[14]),
		.rx_slip_negative(pv[2]), .rx_slip_positive(pv[3]), .tx_slip_positive(pv[4]),
		.tx_slip_negative(pv[5]), .rx_message_end_ch2(pv[6]), .rx_frame_start_ch2(pv[7]),
		.rx_overflow_ch2(pv[8]), .all_sent_ch2(pv[9]), .tx_underrun_ch2(pv[10]),
		.rx_pool_full_ch2(pv[11]), .irq(irq));

	task automatic wrap_up();
		$display("checked %0d values, %0d mismatches", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// A wait that runs out is counted and ends the run
	task automatic stall();
		chk(32'h0000_0000, 32'h0000_0001);
		wrap_up();
	endtask

	// One APB transfer; starts on its own edge so back-to-back calls never collide
	task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'h0};
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			stall();
		end
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask

	task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [7:0] e, input logic ee);
		apb(1'b0, idx, 8'h00);
		chk(rd_data, {24'h00_0000, e});
		chk({31'h0000_0000, rd_err}, {31'h0000_0000, ee});
	endtask

	task automatic pulse(input int s);
		@(posedge pclk);
		pv[s] <= 1'b1;
		@(posedge pclk);
		pv[s] <= 1'b0;
	endtask

	task automatic toggle(input int s);
		@(posedge pclk);
		lv[s] <= ~lv[s];
	endtask

	// Lets a pending irq drop after a clearing read, then waits for the next one
	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b0 && n < 8) begin
			@(posedge pclk);
			n++;
		end
		n = 0;
		while (irq !== 1'b1 && n < 400) begin
			@(posedge pclk);
			n++;
		end
		if (irq !== 1'b1) begin
			stall();
		end
	endtask

	initial begin
		repeat (100000) @(posedge pclk);
		stall();
	end

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hf;
		rx_line_clk = 1'b0;
		rx_run = 1'b0;
		rx_div = 2'h0;
		ss7 = 1'b0;
		abort_cause = 1'b0;
		pv = '0;
		lv = 12'h800;
		err_count = 0;
		samples_checked = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, an unmapped place and a write to a read-only status
		for (int k = 0; k < 4; k++) begin
			rd_chk(IDX_MASK0 + IDX_W'(k), 8'hff, 1'b0);
		end
		for (int k = 0; k < 8; k++) begin
			rd_chk(ZERO_IDX[k], 8'h00, 1'b0);
		end
		rd_chk(10'h3ff, 8'h00, 1'b1);
		wr(IDX_ALARM, 8'hff);
		rd_chk(IDX_ALARM, 8'h00, 1'b0);
		$display("test reset done");
		// Table: masked events stay visible, never reach irq, and one read clears them
		wr(IDX_CFG, 8'h01);
		for (int r = 0; r < NR; r++) begin
			ix = {2'h0, ROWS[r][15:8]};
			ex = ROWS[r][7:0];
			if (ROWS[r][31:24] == 8'h00) begin
				pulse(int'(ROWS[r][23:16]));
			end else if (ROWS[r][31:24] == 8'h01) begin
				toggle(int'(ROWS[r][23:16]));
			end
			repeat (2) @(posedge pclk);
			if (r < 13) begin
				rd_chk(ix, ex, 1'b0);
			end else begin
				rd_chk(ix, ex, 1'b0);
			end
			chk({31'h0000_0000, irq}, 32'h0000_0000);
			rd_chk(ix, 8'h00, 1'b0);
		end
		$display("test table done");
		// Masked pending bit is hidden until unmasked; without vis it is not kept
		pulse(1);
		rd_chk(IDX_SUM, 8'h00, 1'b0);
		wr(IDX_MASK0 + 10'h003, 8'hfe);
		wait_irq();
		apb(1'b0, IDX_SUM, 8'h00);
		chk({31'h0000_0000, |rd_data[3:0]}, 32'h0000_0001);
		rd_chk(IDX_TXEV, 8'h01, 1'b0);
		wr(IDX_MASK0 + 10'h003, 8'hff);
		wr(IDX_CFG, 8'h00);
		pulse(1);
		rd_chk(IDX_TXEV, 8'h00, 1'b0);
		$display("test visibility done");
		// Change select: both edges of blue and red alarm flags report
		wr(IDX_CFG, 8'h03);
		for (int k = 0; k < 4; k++) begin
			toggle(2 + k / 2);
			rd_chk(IDX_ALARM, (k < 2) ? 8'h08 : 8'h04, 1'b0);
		end
		wr(IDX_CFG, 8'h01);
		// PRBS select: every synchroniser change reports, state shown in line readback
		wr(IDX_LOOP, 8'h01);
		for (int k = 0; k < 2; k++) begin
			toggle(9);
			rd_chk(IDX_ERRTMR, 8'h04, 1'b0);
			rd_chk(IDX_LINE, (k == 0) ? 8'h02 : 8'h00, 1'b0);
		end
		wr(IDX_LOOP, 8'h00);
		$display("test change select done");
		// Second timer, errored second and the repeating signal unit error
		@(posedge pclk);
		ss7 <= 1'b1;
		pulse(15);
		rd_chk(IDX_TXEV, 8'h04, 1'b0);
		wr(IDX_ERRSEC_MASK, 8'h20);
		wr(IDX_MASK0 + 10'h001, 8'hbf);
		@(posedge pclk);
		abort_cause <= 1'b1;
		rx_run <= 1'b1;
		wait_irq();
		apb(1'b0, IDX_ERRTMR, 8'h00);
		pulse(12);
		pulse(15);
		rd_chk(IDX_TXEV, 8'h04, 1'b0);
		wait_irq();
		repeat (3) @(posedge pclk);
		rd_chk(IDX_ERRTMR, 8'hc0, 1'b0);
		rd_chk(IDX_TXEV, 8'h04, 1'b0);
		pulse(16);
		pulse(13);
		pulse(14);
		rd_chk(IDX_TXEV, 8'h00, 1'b0);
		wait_irq();
		repeat (3) @(posedge pclk);
		rd_chk(IDX_ERRTMR, 8'h40, 1'b0);
		rd_chk(IDX_TXEV, 8'h00, 1'b0);
		@(posedge pclk);
		rx_run <= 1'b0;
		$display("test second timer done");
		wrap_up();
	end

endmodule

`default_nettype wire
